// ===== rtl/p8g_consts.svh
// Register offsets, reset values and bus codes of the port 8 block.
`ifndef P8G_CONSTS_SVH
`define P8G_CONSTS_SVH

`define P8G_OFS_DIRECTION 8'h00
`define P8G_OFS_OUTPUT_DATA 8'h04
`define P8G_OFS_PIN_OWNER 8'h08

`define P8G_DIR_RESET 8'h00
`define P8G_DATA_RESET 8'h00
`define P8G_PORT_BITS 5
`define P8G_LANE_BITS 8

`define P8G_RESP_OKAY 2'h0
`define P8G_RESP_SLVERR 2'h2

`define P8G_SEL_HOLD 3'h0

`endif

// ===== rtl/p8g_pkg.sv
// Types and shared decoding of the port 8 block.
package p8g_pkg;

    typedef logic [2:0] p8g_io_sel_t;

    typedef enum logic [0:0] {
        P8G_WR_COLLECT = 1'b0,
        P8G_WR_RESP = 1'b1
    } p8g_wr_state_t;

    typedef enum logic [0:0] {
        P8G_RD_IDLE = 1'b0,
        P8G_RD_RESP = 1'b1
    } p8g_rd_state_t;

    typedef enum logic [1:0] {
        P8G_REG_DIRECTION = 2'b00,
        P8G_REG_OUTPUT_DATA = 2'b01,
        P8G_REG_PIN_OWNER = 2'b10,
        P8G_REG_NONE = 2'b11
    } p8g_reg_sel_t;

    typedef struct packed {
        p8g_wr_state_t wrState;
        logic awHeld;
        logic [7:0] awAddr;
        logic awHigh;
        logic wHeld;
        logic [7:0] wData;
        logic wLane0;
        logic [1:0] bResp;
        p8g_rd_state_t rdState;
        logic [31:0] rData;
        logic [1:0] rResp;
    } p8g_bus_state_t;

    typedef struct packed {
        logic pinOut;
        logic pinOe;
        logic timerIn;
    } p8g_pin_state_t;

    // True when the timer channel output owns the pin: select 001 or 01x.
    function automatic logic p8g_timer_drives(input p8g_io_sel_t sel);
        p8g_timer_drives = (sel == 3'h1) || (sel[2:1] == 2'h1);
    endfunction

endpackage

// ===== rtl/p8g_port_reg.sv
// Write-strobed storage latch for one port register.
`timescale 1ns/1ns
module p8g_port_reg #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wrEn,
    input wire logic [WIDTH-1:0] wrData,
    output logic [WIDTH-1:0] value_r
);
    import p8g_pkg::*;

    logic [WIDTH-1:0] value_nxt;

    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("p8g_port_reg WIDTH must lie between 1 and 8");
    end

    always_comb begin
        value_nxt = wrEn ? wrData : value_r;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            value_r <= RESET_VALUE;
        end else begin
            value_r <= value_nxt;
        end
    end
endmodule // p8g_port_reg

// ===== rtl/p8g_pin_cell.sv
// One port pin with its optional timer channel sharing.
`timescale 1ns/1ns
module p8g_pin_cell #(
    parameter bit SHARED = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic dirBit,
    input wire logic latchBit,
    input wire p8g_pkg::p8g_io_sel_t ioSel,
    input wire logic timerOut,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic timerIn
);
    import p8g_pkg::*;

    p8g_pin_state_t state_r;
    p8g_pin_state_t state_nxt;
    logic timerOwns;

    assign timerOwns = SHARED && p8g_timer_drives(ioSel);

    always_comb begin
        state_nxt = state_r;
        if (timerOwns) begin
            state_nxt.pinOut = timerOut;
            state_nxt.pinOe = 1'b1;
        end else begin
            state_nxt.pinOut = latchBit;
            state_nxt.pinOe = dirBit;
        end
        // The channel input always sees the pin, also while the port drives it.
        state_nxt.timerIn = pinIn;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pinOut = state_r.pinOut;
    assign pinOe = state_r.pinOe;
    assign timerIn = state_r.timerIn;
endmodule // p8g_pin_cell

// ===== rtl/p8g_port8_gpio.sv
// Port 8 general-purpose I/O block with timer channel sharing and an AXI4-Lite slave.
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "p8g_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module p8g_port8_gpio #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [ADDR_WIDTH-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [4:0] portPinIn,
    output logic [4:0] portPinOut,
    output logic [4:0] portPinOe,
    input wire p8g_pkg::p8g_io_sel_t chanAIoSel,
    input wire p8g_pkg::p8g_io_sel_t chanBIoSel,
    input wire p8g_pkg::p8g_io_sel_t chanCIoSel,
    input wire p8g_pkg::p8g_io_sel_t chanDIoSel,
    input wire logic [3:0] timerChanOut,
    output logic [3:0] timerChanIn,
    output logic timerExtClockIn
);
    import p8g_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks.

    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr_width
        $error("p8g_port8_gpio ADDR_WIDTH must lie between 8 and 32");
    end

    if ((`P8G_OFS_DIRECTION & 8'h03) != 8'h00
        || (`P8G_OFS_OUTPUT_DATA & 8'h03) != 8'h00
        || (`P8G_OFS_PIN_OWNER & 8'h03) != 8'h00) begin : g_bad_alignment
        $error("p8g_port8_gpio register offsets must be word aligned");
    end

    if (`P8G_OFS_DIRECTION == `P8G_OFS_OUTPUT_DATA
        || `P8G_OFS_DIRECTION == `P8G_OFS_PIN_OWNER
        || `P8G_OFS_OUTPUT_DATA == `P8G_OFS_PIN_OWNER) begin : g_bad_offsets
        $error("p8g_port8_gpio register offsets must all differ");
    end

    if (`P8G_PORT_BITS != 5 || `P8G_PORT_BITS > `P8G_LANE_BITS) begin : g_bad_port_bits
        $error("p8g_port8_gpio serves exactly five pins inside one byte lane");
    end

    if ((`P8G_DIR_RESET >> `P8G_PORT_BITS) != 8'h00
        || (`P8G_DATA_RESET >> `P8G_PORT_BITS) != 8'h00) begin : g_bad_reset
        $error("p8g_port8_gpio reset values must fit the five port bits");
    end

    if (`P8G_SEL_HOLD != 3'h0) begin : g_bad_hold
        $error("p8g_port8_gpio pin 0 select must leave the port in charge");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decoding, shared by the write and the read path.

    function automatic p8g_reg_sel_t decodeReg(input logic [7:0] low, input logic high);
        p8g_reg_sel_t sel;
        sel = P8G_REG_NONE;
        if (!high) begin
            case (low)
                `P8G_OFS_DIRECTION: begin
                    sel = P8G_REG_DIRECTION;
                end
                `P8G_OFS_OUTPUT_DATA: begin
                    sel = P8G_REG_OUTPUT_DATA;
                end
                `P8G_OFS_PIN_OWNER: begin
                    sel = P8G_REG_PIN_OWNER;
                end
                default: begin
                    sel = P8G_REG_NONE;
                end
            endcase
        end
        decodeReg = sel;
    endfunction

    // Any set bit above the low byte makes the address unmapped.
    function automatic logic upperSet(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-1:0] mask;
        mask = {{(ADDR_WIDTH-8){1'b1}}, 8'h00};
        upperSet = |(addr & mask);
    endfunction

    // Unmapped offsets are refused; the read-only owner view takes writes and drops them.
    function automatic logic [1:0] respFor(input p8g_reg_sel_t sel);
        if (sel == P8G_REG_NONE) begin
            respFor = `P8G_RESP_SLVERR;
        end else begin
            respFor = `P8G_RESP_OKAY;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    p8g_bus_state_t state_r;
    p8g_bus_state_t state_nxt;

    logic [4:0] direction_r;
    logic [4:0] outputData_r;
    logic [4:0] portReadValue;
    logic [4:0] timerOwnsPin;
    logic [3:0] ownerView;
    p8g_io_sel_t pinSel [4:0];
    logic [4:0] pinTimerOut;
    logic [4:0] pinTimerIn;
    logic writeFire;
    p8g_reg_sel_t writeSel;
    p8g_reg_sel_t readSel;
    logic dirWe;
    logic dataWe;
    logic awTake;
    logic wTake;
    logic arTake;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshakes.

    // Address and data are each accepted once per write, in either order.
    assign awready = (state_r.wrState == P8G_WR_COLLECT) && !state_r.awHeld;
    assign wready = (state_r.wrState == P8G_WR_COLLECT) && !state_r.wHeld;
    assign arready = (state_r.rdState == P8G_RD_IDLE);

    assign awTake = awvalid && awready;
    assign wTake = wvalid && wready;
    assign arTake = arvalid && arready;

    // The write commits in the cycle in which both halves are held.
    assign writeFire = (state_r.wrState == P8G_WR_COLLECT) && state_r.awHeld
        && state_r.wHeld;
    assign writeSel = decodeReg(state_r.awAddr, state_r.awHigh);
    assign readSel = decodeReg(araddr[7:0], upperSet(araddr));

    // Only the low byte lane carries register data.
    assign dirWe = writeFire && state_r.wLane0 && (writeSel == P8G_REG_DIRECTION);
    assign dataWe = writeFire && state_r.wLane0 && (writeSel == P8G_REG_OUTPUT_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Port registers.

    // The direction bits have no read path, so software must keep its own copy of them.
    p8g_port_reg #(
        .WIDTH(`P8G_PORT_BITS),
        .RESET_VALUE(`P8G_PORT_BITS'(`P8G_DIR_RESET))
    ) u_direction (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wrEn(dirWe),
        .wrData(state_r.wData[4:0]),
        .value_r(direction_r)
    );

    p8g_port_reg #(
        .WIDTH(`P8G_PORT_BITS),
        .RESET_VALUE(`P8G_PORT_BITS'(`P8G_DATA_RESET))
    ) u_output_data (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wrEn(dataWe),
        .wrData(state_r.wData[4:0]),
        .value_r(outputData_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin sharing.

    // Pin 0 has no channel select, so it never gives way to the timer.
    assign pinSel[0] = `P8G_SEL_HOLD;
    assign pinSel[1] = chanAIoSel;
    assign pinSel[2] = chanBIoSel;
    assign pinSel[3] = chanCIoSel;
    assign pinSel[4] = chanDIoSel;
    assign pinTimerOut = {timerChanOut, 1'b0};

    // Each cell registers its drive and its input copy, so every path through a cell has one cycle of delay.
    genvar pin;
    generate
        for (pin = 0; pin < 5; pin++) begin : g_pin
            assign timerOwnsPin[pin] = (pin != 0) && p8g_timer_drives(pinSel[pin]);

            p8g_pin_cell #(
                .SHARED(pin != 0)
            ) u_cell (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .dirBit(direction_r[pin]),
                .latchBit(outputData_r[pin]),
                .ioSel(pinSel[pin]),
                .timerOut(pinTimerOut[pin]),
                .pinIn(portPinIn[pin]),
                .pinOut(portPinOut[pin]),
                .pinOe(portPinOe[pin]),
                .timerIn(pinTimerIn[pin])
            );
        end
    endgenerate

    assign timerChanIn = pinTimerIn[4:1];
    assign timerExtClockIn = pinTimerIn[0];
    assign ownerView = timerOwnsPin[4:1];

    ////////////////////////////////////////////////////////////////////////////
    // Read value of the data register.

    // Output bits read back the latch, input bits the live pin level.
    generate
        for (pin = 0; pin < 5; pin++) begin : g_read
            assign portReadValue[pin] = direction_r[pin]
                ? outputData_r[pin]
                : portPinIn[pin];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the bus slave.

    always_comb begin
        state_nxt = state_r;

        // Each half is captured once; its held flag then closes its ready until the commit.
        if (awTake) begin
            state_nxt.awHeld = 1'b1;
            state_nxt.awAddr = awaddr[7:0];
            state_nxt.awHigh = upperSet(awaddr);
        end
        if (wTake) begin
            state_nxt.wHeld = 1'b1;
            state_nxt.wData = wdata[7:0];
            state_nxt.wLane0 = wstrb[0];
        end

        case (state_r.wrState)
            P8G_WR_COLLECT: begin
                if (writeFire) begin
                    state_nxt.awHeld = 1'b0;
                    state_nxt.wHeld = 1'b0;
                    state_nxt.wrState = P8G_WR_RESP;
                    state_nxt.bResp = respFor(writeSel);
                end
            end
            P8G_WR_RESP: begin
                // The response stands until the master takes it.
                if (bready) begin
                    state_nxt.wrState = P8G_WR_COLLECT;
                    state_nxt.bResp = `P8G_RESP_OKAY;
                end
            end
            default: begin
                state_nxt.wrState = P8G_WR_COLLECT;
            end
        endcase

        case (state_r.rdState)
            P8G_RD_IDLE: begin
                if (arTake) begin
                    state_nxt.rdState = P8G_RD_RESP;
                    state_nxt.rResp = respFor(readSel);
                    state_nxt.rData = 32'h0;
                    case (readSel)
                        P8G_REG_DIRECTION: begin
                            // Direction bits are write-only and read as zero.
                            state_nxt.rData = 32'h0;
                        end
                        P8G_REG_OUTPUT_DATA: begin
                            state_nxt.rData = {27'h0, portReadValue};
                        end
                        P8G_REG_PIN_OWNER: begin
                            state_nxt.rData = {27'h0, ownerView, 1'b0};
                        end
                        default: begin
                            state_nxt.rResp = `P8G_RESP_SLVERR;
                        end
                    endcase
                end
            end
            P8G_RD_RESP: begin
                // Read data fall back to zero once taken, so no stale word lingers.
                if (rready) begin
                    state_nxt.rdState = P8G_RD_IDLE;
                    state_nxt.rData = 32'h0;
                    state_nxt.rResp = `P8G_RESP_OKAY;
                end
            end
            default: begin
                state_nxt.rdState = P8G_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus outputs.

    // Responses come straight from state flip-flops, never from the request inputs.
    assign bvalid = (state_r.wrState == P8G_WR_RESP);
    assign bresp = state_r.bResp;
    assign rvalid = (state_r.rdState == P8G_RD_RESP);
    assign rdata = state_r.rData;
    assign rresp = state_r.rResp;
endmodule // p8g_port8_gpio

// ===== tb/p8g_port8_gpio_sva.sv
// Port-level assertion checker of the port 8 block.
`timescale 1ns/1ns
`include "p8g_consts.svh"
module p8g_port8_gpio_sva #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [4:0] portPinIn,
    input wire logic [4:0] portPinOut,
    input wire logic [4:0] portPinOe,
    input wire p8g_pkg::p8g_io_sel_t chanAIoSel,
    input wire p8g_pkg::p8g_io_sel_t chanDIoSel,
    input wire logic [3:0] timerChanOut,
    input wire logic [3:0] timerChanIn,
    input wire logic timerExtClockIn
);
    import p8g_pkg::*;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////////
    a_chan_a_owns: assert property (rst_b && (chanAIoSel == 3'h1 || chanAIoSel[2:1] == 2'h1)
        |=> portPinOe[1] && portPinOut[1] == $past(timerChanOut[0]))
        else $error("pin 1 not driven by timer channel A");
    a_chan_d_owns: assert property (rst_b && (chanDIoSel == 3'h1 || chanDIoSel[2:1] == 2'h1)
        |=> portPinOe[4] && portPinOut[4] == $past(timerChanOut[3]))
        else $error("pin 4 not driven by timer channel D");
    a_ext_clock_copy: assert property (rst_b && $past(rst_b)
        |-> timerExtClockIn == $past(portPinIn[0]))
        else $error("external clock input does not follow pin 0");
    a_chan_in_copy: assert property (rst_b && $past(rst_b)
        |-> timerChanIn == $past(portPinIn[4:1]))
        else $error("timer channel inputs do not follow pins 4 to 1");
    a_dir_only_write: assert property ($changed(portPinOe[0])
        |-> $past(bvalid) || $past(bvalid, 2))
        else $error("pin 0 direction changed without a write");
    a_write_answer: assert property (rst_b && awvalid && awready && wvalid && wready
        |=> !bvalid ##1 bvalid)
        else $error("write response not on time");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (rst_b && arvalid && arready |=> rvalid)
        else $error("read data not on time");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed while waiting");
    a_read_unmapped: assert property (rst_b && arvalid && arready && araddr != 'h0
        && araddr != 'h4 && araddr != 'h8
        |=> rresp == `P8G_RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");

    c_write: cover property (bvalid && bready);
    c_refused: cover property (rvalid && rresp == `P8G_RESP_SLVERR);
    c_timer_pin: cover property (portPinOe[1] && chanAIoSel == 3'h1);
endmodule // p8g_port8_gpio_sva

bind p8g_port8_gpio p8g_port8_gpio_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.ref_clk, .rst_b,
    .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .portPinIn, .portPinOut, .portPinOe,
    .chanAIoSel, .chanDIoSel, .timerChanOut, .timerChanIn, .timerExtClockIn);

// ===== tb/p8g_pin_model.sv
// Model of the external pins and the timer channel outputs.
`timescale 1ns/1ns
module p8g_pin_model (
    input wire logic [4:0] extLevel,
    input wire logic [3:0] timerDrive,
    input wire logic [4:0] portPinOut,
    input wire logic [4:0] portPinOe,
    output logic [4:0] portPinIn,
    output logic [3:0] timerChanOut
);
    // A pin the block drives shows its drive; otherwise the outside level.
    assign portPinIn = (portPinOe & portPinOut) | (~portPinOe & extLevel);
    assign timerChanOut = timerDrive;
endmodule // p8g_pin_model

// ===== tb/p8g_port8_gpio_test.sv
// Self-checking testbench of the port 8 block.
`timescale 1ns/1ns
`include "p8g_consts.svh"
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin nFail++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module p8g_port8_gpio_test;
    logic ref_clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0, selBus = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0, timerDrive = 0, timerChanOut, timerChanIn;
    logic [4:0] extLevel = 0, portPinIn, portPinOut, portPinOe;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, timerExtClockIn;
    int nFail = 0, testsRun = 0;

    always #20 ref_clk = ~ref_clk;

    p8g_port8_gpio u_p8g_port8_gpio (.ref_clk, .rst_b, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .portPinIn,
        .portPinOut, .portPinOe, .chanAIoSel(selBus[2:0]), .chanBIoSel(selBus[5:3]),
        .chanCIoSel(selBus[8:6]), .chanDIoSel(selBus[11:9]), .timerChanOut, .timerChanIn,
        .timerExtClockIn);
    p8g_pin_model u_p8g_pin_model (.extLevel, .timerDrive, .portPinOut, .portPinOe,
        .portPinIn, .timerChanOut);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        logic slow;
        slow = 1'($urandom);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !slow;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic slow;
        slow = 1'($urandom);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !slow;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Expected {drive enables, drive values masked by the enables}.
    function automatic logic [9:0] expPins(input logic [4:0] dv, input logic [4:0] dt,
        input logic [3:0] tm, input logic [11:0] sl);
        logic [2:0] s;
        expPins = {dv, dt & dv};
        for (int i = 0; i < 4; i++) begin
            s = sl[3*i +: 3];
            if (s == 3'h1 || s[2:1] == 2'h1) begin
                expPins[i+6] = 1'b1;
                expPins[i+1] = tm[i];
            end
        end
    endfunction

    // Expected owner view: bit n set while the timer drives pin n.
    function automatic logic [4:0] expOwn(input logic [11:0] sl);
        logic [2:0] s;
        expOwn = 5'h00;
        for (int i = 0; i < 4; i++) begin
            s = sl[3*i +: 3];
            expOwn[i+1] = (s == 3'h1) || (s[2:1] == 2'h1);
        end
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        nFail++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d, x;
        logic [1:0] r;
        logic [4:0] dir, dat, lvl;
        logic [11:0] sl;
        logic [9:0] e;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        void'($urandom(32'he7a169d6));
        extLevel <= 5'($urandom);
        @(posedge ref_clk);
        `CHK("oe", 5'h00, portPinOe)
        rd(`P8G_OFS_OUTPUT_DATA, d, r);
        `CHK("data", {27'h0, extLevel}, d)
        for (int k = 0; k < 40; k++) begin
            dir = 5'($urandom);
            dat = 5'($urandom);
            sl = (k < 8) ? {4{k[2:0]}} : 12'($urandom);
            selBus <= sl;
            extLevel <= 5'($urandom);
            timerDrive <= 4'($urandom);
            wr(`P8G_OFS_DIRECTION, {27'($urandom), dir}, 4'h1, r);
            `CHK("wresp", `P8G_RESP_OKAY, r)
            wr(`P8G_OFS_OUTPUT_DATA, {27'($urandom), dat}, 4'($urandom) | 4'h1, r);
            repeat (2) @(posedge ref_clk);
            e = expPins(dir, dat, timerDrive, sl);
            `CHK("pins", e, {portPinOe, portPinOut & portPinOe})
            lvl = (e[9:5] & e[4:0]) | (~e[9:5] & extLevel);
            x = {27'h0, (dat & dir) | (lvl & ~dir)};
            rd(`P8G_OFS_OUTPUT_DATA, d, r);
            `CHK("data", x, d)
            rd(`P8G_OFS_PIN_OWNER, d, r);
            `CHK("owner", {27'h0, expOwn(sl)}, d)
        end
        rd(`P8G_OFS_DIRECTION, d, r);
        `CHK("dir read", 32'h0, d)
        wr(`P8G_OFS_OUTPUT_DATA, {27'h0, ~dat}, 4'h0, r);
        rd(`P8G_OFS_OUTPUT_DATA, d, r);
        `CHK("no strobe", x, d)
        wr(12'h00c, 32'h1f, 4'hf, r);
        `CHK("wr err", `P8G_RESP_SLVERR, r)
        rd(12'h104, d, r);
        `CHK("rd err", {`P8G_RESP_SLVERR, 32'h0}, {r, d})
        selBus <= 12'h000;
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK("oe rst", 5'h00, portPinOe)
        wr(`P8G_OFS_DIRECTION, 32'h1f, 4'h1, r);
        rd(`P8G_OFS_OUTPUT_DATA, d, r);
        `CHK("data rst", {24'h0, `P8G_DATA_RESET}, d)
        end_sim();
    end
endmodule // p8g_port8_gpio_test
